// [core/pin_sync.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule

// [core/port_d_pin_multiplexer.sv]
// Purpose: pin owner selection for an 8-bit bidirectional port
// Assumes: APB slave, single clock, function blocks on the same clock
// Notes:   input buffer type is reported, not modelled electrically
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module port_d_pin_multiplexer
    import pin_mux_pkg::*;
#(
    parameter bit HAS_MEMORY_BUS = 1'b1
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // pins
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pin_in,
    output logic      [pin_mux_pkg::PORT_W-1:0] pin_out,
    output logic      [pin_mux_pkg::PORT_W-1:0] pin_oe,
    output logic      [pin_mux_pkg::PORT_W-1:0] pullup_en,
    output logic      [pin_mux_pkg::PORT_W-1:0] threshold_buf_sel,
    // external memory bus
    input  wire logic [pin_mux_pkg::PORT_W-1:0] low_address_data_byte_out,
    input  wire logic                        mem_bus_read_phase,
    output logic      [pin_mux_pkg::PORT_W-1:0] low_address_data_byte_in,
    // parallel host port
    input  wire logic                        parallel_port_active,
    input  wire logic                        parallel_port_drive,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] parallel_port_data_line_out,
    output logic      [pin_mux_pkg::PORT_W-1:0] parallel_port_data_line_in,
    // second serial module
    input  wire logic                        second_serial_data_out,
    input  wire logic                        second_serial_clock_out,
    input  wire logic                        second_twowire_data_oe,
    input  wire logic                        second_twowire_clock_oe,
    input  wire logic                        twowire_threshold_sel,
    output logic                             second_serial_data_in,
    output logic                             second_serial_clock_in,
    output logic                             second_serial_slave_select
);
    import pin_mux_pkg::*;

    localparam int unsigned W = PORT_W;

    // reset release
    logic rst_s1_q;
    logic rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_q   <= 1'b1;
            rst_sync_n <= rst_s1_q;
        end
    end

    // synchronised pins
    logic [W-1:0] pin_s;
    pin_sync #(.W(W)) u_sync (
        .clk  (clk),
        .rst_n(rst_sync_n),
        .din  (pin_in),
        .dout (pin_s)
    );

    // registers
    logic [W-1:0]        latch_q, latch_d;
    logic [W-1:0]        dir_q, dir_d;
    logic [W-1:0]        aux_q, aux_d;
    logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
    logic [31:0]         prdata_q, prdata_d;
    logic                pready_q, pready_d;
    logic                pslverr_q, pslverr_d;

    logic acc;
    logic hit;
    assign acc = psel && penable && !pready_q;
    assign hit = (paddr == OFF_PIN_LEVEL) || (paddr == OFF_LATCH) || (paddr == OFF_DIR)
              || (paddr == OFF_AUX) || (paddr == OFF_CTRL);

    always_comb begin
        latch_d   = latch_q;
        dir_d     = dir_q;
        aux_d     = aux_q;
        ctrl_d    = ctrl_q;
        prdata_d  = prdata_q;
        pready_d  = acc;
        pslverr_d = acc && !hit;
        if (acc && pwrite) begin
            unique case (paddr)
                OFF_PIN_LEVEL: latch_d = pwdata[W-1:0];
                OFF_LATCH:     latch_d = pwdata[W-1:0];
                OFF_DIR:       dir_d   = pwdata[W-1:0];
                OFF_AUX:       aux_d   = pwdata[W-1:0];
                OFF_CTRL:      ctrl_d  = pwdata[CTRL_W-1:0];
                default:       ;
            endcase
        end else if (acc) begin
            unique case (paddr)
                OFF_PIN_LEVEL: prdata_d = {24'h000000, pin_s};
                OFF_LATCH:     prdata_d = {24'h000000, latch_q};
                OFF_DIR:       prdata_d = {24'h000000, dir_q};
                OFF_AUX:       prdata_d = {24'h000000, aux_q};
                OFF_CTRL:      prdata_d = {28'h0000000, ctrl_q};
                default:       prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            latch_q   <= RST_LATCH;
            dir_q     <= RST_DIR;
            aux_q     <= RST_AUX;
            ctrl_q    <= RST_CTRL[CTRL_W-1:0];
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            latch_q   <= latch_d;
            dir_q     <= dir_d;
            aux_q     <= aux_d;
            ctrl_q    <= ctrl_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ownership
    logic mem_en;
    logic pp_en;
    logic twowire;
    logic ser_en;
    assign mem_en  = HAS_MEMORY_BUS && !ctrl_q[CTRL_MEM_DIS_BIT];
    assign pp_en   = ctrl_q[CTRL_PLACE_BIT] && parallel_port_active;
    assign twowire = ctrl_q[CTRL_TWOWIRE_BIT];
    assign ser_en  = ctrl_q[CTRL_SERIAL_EN_BIT];

    logic [W-1:0] out_d, oe_d, pu_d, thr_d, ad_in_d, pp_in_d;
    logic [W-1:0] out_q, oe_q, pu_q, thr_q, ad_in_q, pp_in_q;
    logic         sdi_d, sck_d, ss_d;
    logic         sdi_q, sck_q, ss_q;

    always_comb begin
        out_d   = latch_q;
        oe_d    = ~dir_q;
        thr_d   = '0;
        ad_in_d = ad_in_q;
        pp_in_d = pin_s;
        // serial functions replace latch data, and also the drive enables of the two-wire pins and the slave select pin
        if (ser_en) begin
            if (!dir_q[PIN_SDO]) begin
                out_d[PIN_SDO] = second_serial_data_out;
            end
            if (twowire) begin
                oe_d[PIN_SDI]  = second_twowire_data_oe;
                out_d[PIN_SDI] = 1'b0;
                thr_d[PIN_SDI] = twowire_threshold_sel;
                oe_d[PIN_SCK]  = second_twowire_clock_oe;
                out_d[PIN_SCK] = 1'b0;
                thr_d[PIN_SCK] = twowire_threshold_sel;
            end else if (!dir_q[PIN_SCK]) begin
                out_d[PIN_SCK] = second_serial_clock_out;
            end
            // slave select is an input whatever the direction bit says
            oe_d[PIN_SS]  = 1'b0;
            thr_d[PIN_SS] = 1'b1;
        end
        if (pp_en) begin
            out_d = parallel_port_data_line_out;
            oe_d  = {W{parallel_port_drive}};
            thr_d = '1;
        end
        if (mem_en) begin
            out_d = low_address_data_byte_out;
            oe_d  = {W{!mem_bus_read_phase}};
            thr_d = '1;
            if (mem_bus_read_phase) begin
                ad_in_d = pin_s;
            end
        end
        // pull-ups gated by the common enable and by output drive
        pu_d = {W{aux_q[AUX_PULLUP_BIT]}} & ~oe_d;
    end

    always_comb begin
        sdi_d = (ser_en && !twowire && dir_q[PIN_SDI]) ? pin_s[PIN_SDI]
              : (ser_en && twowire) ? pin_s[PIN_SDI] : 1'b0;
        sck_d = (ser_en && (twowire || dir_q[PIN_SCK])) ? pin_s[PIN_SCK]
              : 1'b0;
        ss_d  = ser_en ? pin_s[PIN_SS] : 1'b1;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_q   <= '0;
            oe_q    <= '0;
            pu_q    <= '0;
            thr_q   <= '0;
            ad_in_q <= '0;
            pp_in_q <= '0;
            sdi_q   <= 1'b0;
            sck_q   <= 1'b0;
            ss_q    <= 1'b1;
        end else begin
            out_q   <= out_d;
            oe_q    <= oe_d;
            pu_q    <= pu_d;
            thr_q   <= thr_d;
            ad_in_q <= ad_in_d;
            pp_in_q <= pp_in_d;
            sdi_q   <= sdi_d;
            sck_q   <= sck_d;
            ss_q    <= ss_d;
        end
    end

    assign pin_out                    = out_q;
    assign pin_oe                     = oe_q;
    assign pullup_en                  = pu_q;
    assign threshold_buf_sel          = thr_q;
    assign low_address_data_byte_in   = ad_in_q;
    assign parallel_port_data_line_in = pp_in_q;
    assign second_serial_data_in      = sdi_q;
    assign second_serial_clock_in     = sck_q;
    assign second_serial_slave_select = ss_q;

    // checks
    property p_mem_drive;
        @(posedge clk) disable iff (!rst_sync_n)
        (mem_en && !mem_bus_read_phase) |=> (pin_out == $past(low_address_data_byte_out))
                                            && (pin_oe == 8'hFF);
    endproperty
    a_mem_drive: assert property (p_mem_drive) else $error("memory bus not driving pins");

    property p_mem_read;
        @(posedge clk) disable iff (!rst_sync_n)
        (mem_en && mem_bus_read_phase) |=> (pin_oe == 8'h00) && (threshold_buf_sel == 8'hFF)
                                           && (low_address_data_byte_in == $past(pin_s));
    endproperty
    a_mem_read: assert property (p_mem_read) else $error("memory read capture wrong");

    property p_mem_over_pp;
        @(posedge clk) disable iff (!rst_sync_n)
        (mem_en && pp_en) |=> (pin_out == $past(low_address_data_byte_out));
    endproperty
    a_mem_over_pp: assert property (p_mem_over_pp) else $error("memory bus lost priority");

    property p_pp_route;
        @(posedge clk) disable iff (!rst_sync_n)
        (!mem_en && pp_en && parallel_port_drive) |=>
            (pin_out == $past(parallel_port_data_line_out)) && (threshold_buf_sel == 8'hFF);
    endproperty
    a_pp_route: assert property (p_pp_route) else $error("parallel port not routed");

    property p_sdo;
        @(posedge clk) disable iff (!rst_sync_n)
        (!mem_en && !pp_en && ser_en && !dir_q[PIN_SDO]) |=>
            (pin_out[PIN_SDO] == $past(second_serial_data_out)) && pin_oe[PIN_SDO];
    endproperty
    a_sdo: assert property (p_sdo) else $error("serial data out not on pin");

    property p_ss;
        @(posedge clk) disable iff (!rst_sync_n)
        (!mem_en && !pp_en && ser_en) |=> !pin_oe[PIN_SS] && threshold_buf_sel[PIN_SS]
                                          && (second_serial_slave_select == $past(pin_s[PIN_SS]));
    endproperty
    a_ss: assert property (p_ss) else $error("slave select path wrong");

    property p_plain;
        @(posedge clk) disable iff (!rst_sync_n)
        (!mem_en && !pp_en && !ser_en) |=> (pin_oe == ~$past(dir_q)) && (pin_out == $past(latch_q));
    endproperty
    a_plain: assert property (p_plain) else $error("plain port drive wrong");

    property p_pullup;
        @(posedge clk) disable iff (!rst_sync_n)
        !aux_q[AUX_PULLUP_BIT] |=> (pullup_en == 8'h00);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up on while disabled");

    property p_pullup_drive;
        @(posedge clk) disable iff (!rst_sync_n)
        (pin_oe != 8'h00) |-> ((pullup_en & pin_oe) == 8'h00);
    endproperty
    a_pullup_drive: assert property (p_pullup_drive) else $error("pull-up on while driving");
endmodule

// [dv/pin_partner.sv]
// Purpose: pad-side model of the eight port pins
// Assumes: external drivers selected per pin by ext_en
// Notes:   an undriven pin without pull-up toggles, never holds
`timescale 1ns/1ns
module pin_partner
    import pin_mux_pkg::*;
(
    // clock
    input  wire logic              clk,
    // device pad side
    input  wire logic [PORT_W-1:0] pin_out,
    input  wire logic [PORT_W-1:0] pin_oe,
    input  wire logic [PORT_W-1:0] pullup_en,
    // external devices
    input  wire logic [PORT_W-1:0] ext_val,
    input  wire logic [PORT_W-1:0] ext_en,
    output logic      [PORT_W-1:0] pin_in
);
    // known start, else a floating pad stays unknown for the whole run
    logic [PORT_W-1:0] last_q = '0;

    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~last_q[i];
        end
    end

    // a floating pad must not look stable to the synchroniser
    always @(posedge clk) begin
        last_q <= pin_in;
    end
endmodule

// [dv/port_d_pin_multiplexer_tb_top.sv]
// Purpose: register and pin-ownership tests of the port multiplexer
// Assumes: APB answer awaited until pready, pin sync within 8 cycles
// Notes:   small package variant shares all inputs, only its pins are compared
`timescale 1ns/1ns
module port_d_pin_multiplexer_tb_top;
    import pin_mux_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, pin_in, pin_out, pin_oe, pullup_en, thr;
    logic [7:0]  ad_out, ad_in, pp_out, pp_in, ext_val, ext_en;
    logic [31:0] pwdata, prdata, rdat;
    logic        rd_phase, pp_act, pp_drv, sdo, sck, sda_oe, scl_oe, tw_thr;
    logic        sdi, sck_in, ss, rerr;
    logic [7:0]  sm_out;
    int          n_fail = 0;
    int          checks = 0;

    port_d_pin_multiplexer dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .threshold_buf_sel(thr), .low_address_data_byte_out(ad_out),
        .mem_bus_read_phase(rd_phase), .low_address_data_byte_in(ad_in),
        .parallel_port_active(pp_act), .parallel_port_drive(pp_drv),
        .parallel_port_data_line_out(pp_out), .parallel_port_data_line_in(pp_in),
        .second_serial_data_out(sdo), .second_serial_clock_out(sck),
        .second_twowire_data_oe(sda_oe), .second_twowire_clock_oe(scl_oe),
        .twowire_threshold_sel(tw_thr), .second_serial_data_in(sdi),
        .second_serial_clock_in(sck_in), .second_serial_slave_select(ss)
    );

    port_d_pin_multiplexer #(.HAS_MEMORY_BUS(1'b0)) dut_small (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .pin_in(pin_in), .pin_out(sm_out), .pin_oe(),
        .pullup_en(), .threshold_buf_sel(), .low_address_data_byte_out(ad_out),
        .mem_bus_read_phase(rd_phase), .low_address_data_byte_in(),
        .parallel_port_active(pp_act), .parallel_port_drive(pp_drv),
        .parallel_port_data_line_out(pp_out), .parallel_port_data_line_in(),
        .second_serial_data_out(sdo), .second_serial_clock_out(sck),
        .second_twowire_data_oe(sda_oe), .second_twowire_clock_oe(scl_oe),
        .twowire_threshold_sel(tw_thr), .second_serial_data_in(),
        .second_serial_clock_in(), .second_serial_slave_select()
    );

    pin_partner pads (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; request held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rdat, {24'h0, exp});
        chk(rerr, err);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        final_report();
    end

    initial begin
        {rst_n, psel, penable, pwrite, rd_phase, pp_act, pp_drv} = '0;
        {sdo, sck, sda_oe, scl_oe, tw_thr} = '0;
        {paddr, ad_out, pp_out, ext_val, ext_en} = '0;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        chk(pin_oe, 8'h00);
        chk(pullup_en, 8'h00);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFF_LATCH, RST_LATCH, 1'b0);
        rd(OFF_DIR, 8'hFF, 1'b0);
        rd(OFF_AUX, 8'h00, 1'b0);
        rd(OFF_CTRL, RST_CTRL, 1'b0);
        rd(8'h14, 8'h00, 1'b1);
        // plain port drive, pull-ups, pin read
        wr(OFF_LATCH, 8'hA5);
        wr(OFF_DIR, 8'h00);
        repeat (2) @(posedge clk);
        chk(pin_oe, 8'hFF);
        chk(pin_out, 8'hA5);
        wr(OFF_AUX, 8'h80);
        wr(OFF_DIR, 8'hF0);
        ext_en <= 8'hF0;
        ext_val <= 8'hC0;
        repeat (8) @(posedge clk);
        chk(pullup_en, 8'hF0);
        rd(OFF_PIN_LEVEL, 8'hC5, 1'b0);
        wr(OFF_AUX, 8'h00);
        repeat (2) @(posedge clk);
        chk(pullup_en, 8'h00);
        // memory bus outranks parallel port and serial
        ad_out <= 8'h5A;
        pp_act <= 1'b1;
        pp_drv <= 1'b1;
        pp_out <= 8'h0C;
        sdo <= 1'b1;
        wr(OFF_CTRL, 8'h0A);
        repeat (2) @(posedge clk);
        chk(pin_oe, 8'hFF);
        chk(pin_out, 8'h5A);
        chk(sm_out, 8'h0C);
        rd_phase <= 1'b1;
        ext_en <= 8'hFF;
        ext_val <= 8'h96;
        repeat (8) @(posedge clk);
        chk(pin_oe, 8'h00);
        chk(thr, 8'hFF);
        chk(ad_in, 8'h96);
        rd_phase <= 1'b0;
        ext_en <= 8'h00;
        // parallel port outranks serial and latch
        wr(OFF_CTRL, 8'h0B);
        repeat (2) @(posedge clk);
        chk(pin_oe, 8'hFF);
        chk(pin_out, 8'h0C);
        pp_drv <= 1'b0;
        ext_en <= 8'hFF;
        ext_val <= 8'h69;
        repeat (8) @(posedge clk);
        chk(pin_oe, 8'h00);
        chk(thr, 8'hFF);
        chk(pp_in, 8'h69);
        // spi pins
        pp_act <= 1'b0;
        sck <= 1'b1;
        ext_en <= 8'hA0;
        ext_val <= 8'h20;
        wr(OFF_CTRL, 8'h09);
        wr(OFF_LATCH, 8'h00);
        wr(OFF_DIR, 8'hAF);
        repeat (8) @(posedge clk);
        chk(pin_oe & 8'hF0, 8'h50);
        chk(pin_out & 8'h50, 8'h50);
        chk(sdi, 1'b1);
        chk(ss, 1'b0);
        chk(thr & 8'hF0, 8'h80);
        ext_en <= 8'hE0;
        ext_val <= 8'hC0;
        wr(OFF_DIR, 8'hEF);
        repeat (8) @(posedge clk);
        chk(sck_in, 1'b1);
        chk(ss, 1'b1);
        // two-wire pins
        ext_en <= 8'h00;
        sda_oe <= 1'b1;
        tw_thr <= 1'b1;
        wr(OFF_CTRL, 8'h0D);
        wr(OFF_DIR, 8'hFF);
        repeat (2) @(posedge clk);
        chk(pin_oe & 8'h60, 8'h20);
        chk(pin_out & 8'h60, 8'h00);
        chk(thr & 8'h60, 8'h60);
        sda_oe <= 1'b0;
        scl_oe <= 1'b1;
        ext_en <= 8'h20;
        ext_val <= 8'h20;
        repeat (8) @(posedge clk);
        chk(pin_oe & 8'h60, 8'h40);
        chk(sdi, 1'b1);
        final_report();
    end
endmodule

// [shared/pin_mux_pkg.sv]
// Purpose: constants shared by the port pin multiplexer
// Assumes: APB register map, 32-bit data, one register per aligned word
// Notes:   five registers, offsets chosen for this block
package pin_mux_pkg;
    localparam int unsigned PORT_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h00;
    localparam logic [7:0] OFF_LATCH     = 8'h04;
    localparam logic [7:0] OFF_DIR       = 8'h08;
    localparam logic [7:0] OFF_AUX       = 8'h0C;
    localparam logic [7:0] OFF_CTRL      = 8'h10;

    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR   = 8'hFF;
    localparam logic [7:0] RST_AUX   = 8'h00;
    localparam logic [7:0] RST_CTRL  = 8'h01;

    // field positions
    localparam int unsigned AUX_PULLUP_BIT    = 7;
    localparam int unsigned CTRL_MEM_DIS_BIT  = 0;
    localparam int unsigned CTRL_PLACE_BIT    = 1;
    localparam int unsigned CTRL_TWOWIRE_BIT  = 2;
    localparam int unsigned CTRL_SERIAL_EN_BIT = 3;
    localparam int unsigned CTRL_W            = 4;

    // pin positions of serial functions
    localparam int unsigned PIN_SDO = 4;
    localparam int unsigned PIN_SDI = 5;
    localparam int unsigned PIN_SCK = 6;
    localparam int unsigned PIN_SS  = 7;

    localparam int unsigned SYNC_STAGES = 3;
endpackage
